// File: rtl/iqr_pkg.sv
/*
  Package for the invalidation queue register block: offsets, fields, reset values, types.
  Assumes a 32-bit AXI4-Lite register bus and one clock domain.
*/
package iqr_pkg;
  localparam logic [7:0]  OFF_HEAD_LO   = 8'h80;
  localparam logic [7:0]  OFF_HEAD_HI   = 8'h84;
  localparam logic [7:0]  OFF_TAIL_LO   = 8'h88;
  localparam logic [7:0]  OFF_TAIL_HI   = 8'h8C;
  localparam logic [7:0]  OFF_BASE_LO   = 8'h90;
  localparam logic [7:0]  OFF_BASE_HI   = 8'h94;
  localparam logic [7:0]  OFF_WAIT_STAT = 8'h9C;
  localparam logic [7:0]  OFF_CTRL      = 8'hA8;
  localparam logic [7:0]  OFF_IRQ_STAT  = 8'hAC;
  localparam logic [7:0]  OFF_IRQ_MASK  = 8'hB0;
  localparam int          HOST_ADDRESS_WIDTH           = 48;
  localparam int          OFFS_MSB      = 18;
  localparam int          OFFS_LSB      = 4;
  localparam int          BASE_LSB      = 12;
  localparam int          SIZE_MSB      = 2;
  localparam int          CTRL_EN_BIT   = 0;
  localparam int          CTRL_QI_BIT   = 1;
  localparam logic [14:0] OFFS_RESET    = 15'h0000;
  localparam logic [35:0] BASE_RESET    = 36'h0;
  localparam logic [2:0]  SIZE_RESET    = 3'h0;
  localparam logic [1:0]  RESP_OKAY     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR   = 2'h2;

  typedef struct packed {
    logic        valid;
    logic [63:0] addr;
  } iqr_fetch_t;

  typedef enum logic [2:0] {
    FS_IDLE = 3'b001,
    FS_REQ  = 3'b010,
    FS_OFF  = 3'b100
  } iqr_fetch_state_t;
endpackage : iqr_pkg

// File: rtl/iqr_fetch.sv
/*
  Descriptor fetch sequencer: walks head toward tail and issues fetch requests.
  Assumes memory answers each request with a one-cycle done pulse.
*/
`timescale 1ns/1ps
module iqr_fetch (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 enable,
  input  wire logic [14:0]          tailOffset,
  input  wire logic [35:0]          baseAddr,
  input  wire logic [2:0]           sizeExp,
  input  wire logic                 fetchDone,
  output logic                      fetchValid,
  output logic [63:0]               fetchAddr,
  output logic [14:0]               headOffset
);
  iqr_pkg::iqr_fetch_state_t state;
  iqr_pkg::iqr_fetch_state_t next_state;
  logic [14:0]               next_headOffset;
  logic [14:0]               lastEntry;

  always_comb
  begin
    // Entries = 2^(X+8); last index masks wrap
    lastEntry       = 15'((17'h1 << (5'(sizeExp) + 5'h8)) - 17'h1);
    next_state      = state;
    next_headOffset = headOffset;
    case (state)
      iqr_pkg::FS_IDLE:
        if (!enable)
          next_headOffset = iqr_pkg::OFFS_RESET;
        else if (headOffset != tailOffset)
          next_state = iqr_pkg::FS_REQ;
      iqr_pkg::FS_REQ:
        if (fetchDone)
        begin
          next_headOffset = (headOffset == lastEntry) ? 15'h0000 : headOffset + 15'h0001;
          next_state      = iqr_pkg::FS_IDLE;
        end
      default:
        next_state = iqr_pkg::FS_IDLE;
    endcase
    // Disable aborts an in-flight fetch; memory must tolerate a dropped request
    if (!enable)
    begin
      next_state      = iqr_pkg::FS_IDLE;
      next_headOffset = iqr_pkg::OFFS_RESET;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      state      <= iqr_pkg::FS_IDLE;
      headOffset <= iqr_pkg::OFFS_RESET;
      fetchValid <= 1'b0;
      fetchAddr  <= 64'h0;
    end
    else
    begin
      state      <= next_state;
      headOffset <= next_headOffset;
      fetchValid <= (next_state == iqr_pkg::FS_REQ);
      fetchAddr  <= {16'h0, baseAddr, 12'h000} + {45'h0, next_headOffset, 4'h0};
    end
  end

  chk_head_cleared: assert property (@(posedge core_clk) disable iff (!rst_n)
    !enable |=> headOffset == 15'h0000) else $error("head not cleared when disabled");
  chk_head_step: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == iqr_pkg::FS_REQ && fetchDone && enable && headOffset != lastEntry)
    |=> headOffset == $past(headOffset) + 15'h0001) else $error("head did not advance");
  chk_head_wrap: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == iqr_pkg::FS_REQ && fetchDone && enable && headOffset == lastEntry)
    |=> headOffset == 15'h0000) else $error("head did not wrap");
  chk_no_fetch_empty: assert property (@(posedge core_clk) disable iff (!rst_n)
    (state == iqr_pkg::FS_IDLE && headOffset == tailOffset) |=> !fetchValid)
    else $error("fetch with empty queue");
endmodule : iqr_fetch

// File: rtl/iqr_regs.sv
/*
  Invalidation queue register bank with AXI4-Lite slave, wait-done interrupt and fetch.
  Assumes a single clock, synchronous active-low reset, same-domain event inputs.
*/
// The AXI4-Lite register port was left to the implementer.
// How it works
// - With queued invalidation unsupported, head, tail, base/size and wait status read zero.
// - Head offset lives read-only in bits 18:4 and names the next entry to fetch.
// - Head offset is held at zero whenever the queue is disabled.
// - Tail offset in bits 18:4 is writable and marks where software puts the next entry.
// - Bits 63:12 of the base register hold the 4KB-aligned queue start used for fetches.
// - Base bits at and above the host address width are not stored.
// - The base field reads back what software last wrote in bits 47:12; higher bits read zero.
// - Size value X means 2^X pages, that is 2^(X+8) descriptor entries.
// - Wait-done in bit 0 is set by a flagged wait completion and cleared by writing one.
// - A completion only raises a new pending interrupt if wait-done was clear.
`timescale 1ns/1ps
module iqr_regs (
  input  wire logic                 core_clk,
  input  wire logic                 rst_n,
  input  wire logic                 qiSupported,
  input  wire logic [7:0]           s_axi_awaddr,
  input  wire logic                 s_axi_awvalid,
  output logic                      s_axi_awready,
  input  wire logic [31:0]          s_axi_wdata,
  input  wire logic [3:0]           s_axi_wstrb,
  input  wire logic                 s_axi_wvalid,
  output logic                      s_axi_wready,
  output logic [1:0]                s_axi_bresp,
  output logic                      s_axi_bvalid,
  input  wire logic                 s_axi_bready,
  input  wire logic [7:0]           s_axi_araddr,
  input  wire logic                 s_axi_arvalid,
  output logic                      s_axi_arready,
  output logic [31:0]               s_axi_rdata,
  output logic [1:0]                s_axi_rresp,
  output logic                      s_axi_rvalid,
  input  wire logic                 s_axi_rready,
  input  wire logic                 waitDone,
  input  wire logic                 fetchDone,
  output logic                      fetchValid,
  output logic [63:0]               fetchAddr,
  output logic                      irq
);
  logic        awHeld;
  logic        wHeld;
  logic [7:0]  awAddr;
  logic [31:0] wData;
  logic [3:0]  wStrb;
  logic        next_awHeld;
  logic        next_wHeld;
  logic [7:0]  next_awAddr;
  logic [31:0] next_wData;
  logic [3:0]  next_wStrb;
  logic        next_bvalid;
  logic [1:0]  next_bresp;
  logic        next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0]  next_rresp;
  logic        doWrite;

  logic [14:0] tailOffset;
  logic [35:0] baseAddr;
  logic [2:0]  sizeExp;
  logic        queueEnable;
  logic        waitDoneFlag;
  logic        irqStatus;
  logic        irqMask;
  logic [14:0] next_tailOffset;
  logic [35:0] next_baseAddr;
  logic [2:0]  next_sizeExp;
  logic        next_queueEnable;
  logic        next_waitDoneFlag;
  logic        next_irqStatus;
  logic        next_irqMask;
  logic [14:0] headOffset;
  logic        qiOn;
  logic [31:0] tailMerged;
  logic [31:0] baseLoMerged;
  logic [31:0] baseHiMerged;

  // Byte-lane merge of one write word
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (strb[i])
        r[8*i +: 8] = nw[8*i +: 8];
    return r;
  endfunction : merge

  function automatic logic known(input logic [7:0] a);
    return a == iqr_pkg::OFF_HEAD_LO || a == iqr_pkg::OFF_HEAD_HI
        || a == iqr_pkg::OFF_TAIL_LO || a == iqr_pkg::OFF_TAIL_HI
        || a == iqr_pkg::OFF_BASE_LO || a == iqr_pkg::OFF_BASE_HI
        || a == iqr_pkg::OFF_WAIT_STAT || a == iqr_pkg::OFF_CTRL
        || a == iqr_pkg::OFF_IRQ_STAT || a == iqr_pkg::OFF_IRQ_MASK;
  endfunction : known

  assign qiOn    = qiSupported;
  assign doWrite = awHeld && wHeld && !s_axi_bvalid;

  // Lane merges held in nets, since a function result cannot be sliced in place
  assign tailMerged   = merge({13'h0, tailOffset, 4'h0}, wData, wStrb);
  assign baseLoMerged = merge({baseAddr[19:0], 9'h0, sizeExp}, wData, wStrb);
  assign baseHiMerged = merge({16'h0, baseAddr[35:20]}, wData, wStrb);

  // Bus channel capture and responses
  always_comb
  begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld  = wHeld;
    next_wData  = wData;
    next_wStrb  = wStrb;
    next_bvalid = s_axi_bvalid && !s_axi_bready;
    next_bresp  = s_axi_bresp;
    next_rvalid = s_axi_rvalid && !s_axi_rready;
    next_rdata  = s_axi_rdata;
    next_rresp  = s_axi_rresp;
    if (s_axi_awvalid && s_axi_awready)
    begin
      next_awHeld = 1'b1;
      next_awAddr = {s_axi_awaddr[7:2], 2'b00};
    end
    if (s_axi_wvalid && s_axi_wready)
    begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite)
    begin
      next_awHeld = 1'b0;
      next_wHeld  = 1'b0;
      next_bvalid = 1'b1;
      next_bresp  = known(awAddr) ? iqr_pkg::RESP_OKAY : iqr_pkg::RESP_SLVERR;
    end
    if (s_axi_arvalid && s_axi_arready)
    begin
      next_rvalid = 1'b1;
      next_rresp  = known({s_axi_araddr[7:2], 2'b00}) ? iqr_pkg::RESP_OKAY
                                                      : iqr_pkg::RESP_SLVERR;
      next_rdata  = 32'h0;
      // Queue registers read zero when the feature is absent
      if (qiOn)
        case ({s_axi_araddr[7:2], 2'b00})
          iqr_pkg::OFF_HEAD_LO:   next_rdata = {13'h0, headOffset, 4'h0};
          iqr_pkg::OFF_TAIL_LO:   next_rdata = {13'h0, tailOffset, 4'h0};
          iqr_pkg::OFF_BASE_LO:   next_rdata = {baseAddr[19:0], 9'h0, sizeExp};
          iqr_pkg::OFF_BASE_HI:   next_rdata = {16'h0, baseAddr[35:20]};
          iqr_pkg::OFF_WAIT_STAT: next_rdata = {31'h0, waitDoneFlag};
          default:                next_rdata = 32'h0;
        endcase
      case ({s_axi_araddr[7:2], 2'b00})
        iqr_pkg::OFF_CTRL:     next_rdata = {30'h0, qiOn, queueEnable};
        iqr_pkg::OFF_IRQ_STAT: next_rdata = {31'h0, irqStatus};
        iqr_pkg::OFF_IRQ_MASK: next_rdata = {31'h0, irqMask};
        default:               next_rdata = next_rdata;
      endcase
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      awHeld        <= 1'b0;
      awAddr        <= 8'h00;
      wHeld         <= 1'b0;
      wData         <= 32'h0;
      wStrb         <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_arready <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= iqr_pkg::RESP_OKAY;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0;
      s_axi_rresp   <= iqr_pkg::RESP_OKAY;
    end
    else
    begin
      awHeld        <= next_awHeld;
      awAddr        <= next_awAddr;
      wHeld         <= next_wHeld;
      wData         <= next_wData;
      wStrb         <= next_wStrb;
      // Ready only while the slot is empty, so one write is held at a time
      s_axi_awready <= !next_awHeld && !next_bvalid && !(s_axi_awvalid && s_axi_awready);
      s_axi_wready  <= !next_wHeld && !next_bvalid && !(s_axi_wvalid && s_axi_wready);
      s_axi_arready <= !next_rvalid && !(s_axi_arvalid && s_axi_arready);
      s_axi_bvalid  <= next_bvalid;
      s_axi_bresp   <= next_bresp;
      s_axi_rvalid  <= next_rvalid;
      s_axi_rdata   <= next_rdata;
      s_axi_rresp   <= next_rresp;
    end
  end

  // Register state update
  always_comb
  begin
    next_tailOffset   = tailOffset;
    next_baseAddr     = baseAddr;
    next_sizeExp      = sizeExp;
    next_queueEnable  = queueEnable;
    next_waitDoneFlag = waitDoneFlag;
    next_irqStatus    = irqStatus;
    next_irqMask      = irqMask;
    if (doWrite)
      case (awAddr)
        iqr_pkg::OFF_TAIL_LO:
          if (qiOn)
            next_tailOffset = tailMerged[18:4];
        iqr_pkg::OFF_BASE_LO:
          if (qiOn)
          begin
            next_baseAddr[19:0] = baseLoMerged[31:12];
            next_sizeExp        = baseLoMerged[2:0];
          end
        iqr_pkg::OFF_BASE_HI:
          if (qiOn)
            next_baseAddr[35:20] = baseHiMerged[15:0];
        iqr_pkg::OFF_WAIT_STAT:
          if (qiOn && wStrb[0] && wData[0])
            next_waitDoneFlag = 1'b0;
        iqr_pkg::OFF_CTRL:
          if (wStrb[0])
            next_queueEnable = wData[iqr_pkg::CTRL_EN_BIT] && qiOn;
        iqr_pkg::OFF_IRQ_STAT:
          if (wStrb[0] && wData[0])
            next_irqStatus = 1'b0;
        iqr_pkg::OFF_IRQ_MASK:
          if (wStrb[0])
            next_irqMask = wData[0];
        default:
          next_tailOffset = tailOffset;
      endcase
    // Set wins over a clear in the same cycle
    if (waitDone && qiOn)
    begin
      if (!waitDoneFlag)
        next_irqStatus = 1'b1;
      next_waitDoneFlag = 1'b1;
    end
    if (!qiOn)
    begin
      next_queueEnable = 1'b0;
      next_waitDoneFlag = 1'b0;
    end
  end

  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      tailOffset   <= iqr_pkg::OFFS_RESET;
      baseAddr     <= iqr_pkg::BASE_RESET;
      sizeExp      <= iqr_pkg::SIZE_RESET;
      queueEnable  <= 1'b0;
      waitDoneFlag <= 1'b0;
      irqStatus    <= 1'b0;
      irqMask      <= 1'b0;
      irq          <= 1'b0;
    end
    else
    begin
      tailOffset   <= next_tailOffset;
      baseAddr     <= next_baseAddr;
      sizeExp      <= next_sizeExp;
      queueEnable  <= next_queueEnable;
      waitDoneFlag <= next_waitDoneFlag;
      irqStatus    <= next_irqStatus;
      irqMask      <= next_irqMask;
      irq          <= next_irqStatus && next_irqMask;
    end
  end

  iqr_fetch u_fetch (
    .core_clk   (core_clk),
    .rst_n      (rst_n),
    .enable     (queueEnable),
    .tailOffset (tailOffset),
    .baseAddr   (baseAddr),
    .sizeExp    (sizeExp),
    .fetchDone  (fetchDone),
    // Sequencer flops drive the pins directly; a second stage would hold a stale request
    .fetchValid (fetchValid),
    .fetchAddr  (fetchAddr),
    .headOffset (headOffset)
  );

  chk_wait_set: assert property (@(posedge core_clk) disable iff (!rst_n)
    (waitDone && qiOn) |=> waitDoneFlag) else $error("wait-done not set");
  chk_new_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
    (waitDone && qiOn && !waitDoneFlag) |=> irqStatus) else $error("pending not raised");
  chk_old_pending: assert property (@(posedge core_clk) disable iff (!rst_n)
    (waitDone && waitDoneFlag && !irqStatus && !doWrite) |=> !irqStatus)
    else $error("pending raised twice");
  chk_irq_level: assert property (@(posedge core_clk) disable iff (!rst_n)
    irq == (irqStatus && irqMask)) else $error("irq mismatch");
  chk_absent_zero: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready && !qiOn
     && {s_axi_araddr[7:2], 2'b00} == iqr_pkg::OFF_TAIL_LO) |=> s_axi_rdata == 32'h0)
    else $error("absent register not zero");
  chk_resp_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
    (s_axi_arvalid && s_axi_arready) |=> s_axi_rvalid) else $error("read answer late");
endmodule : iqr_regs

// File: sim/iqr_mem_model.sv
/*
  System memory model that answers descriptor fetch requests of the register bank.
  Assumes fetchValid holds until a one-cycle fetchDone; lag sets the answer delay.
*/
`timescale 1ns/1ps
module iqr_mem_model (
  input  wire logic        core_clk,
  input  wire logic        rst_n,
  input  wire logic [3:0]  lag,
  input  wire logic        fetchValid,
  input  wire logic [63:0] fetchAddr,
  output logic             fetchDone,
  output logic [15:0]      fetchCount,
  output logic [63:0]      lastAddr
);
  logic [3:0] waitCnt;

  // One idle cycle after each answer, so a held request is never counted twice
  always_ff @(posedge core_clk)
  begin
    if (!rst_n)
    begin
      fetchDone  <= 1'h0;
      waitCnt    <= 4'h0;
      fetchCount <= 16'h0;
      lastAddr   <= 64'h0;
    end
    else
    begin
      fetchDone <= 1'h0;
      if (fetchDone || !fetchValid)
        waitCnt <= 4'h0;
      else if (waitCnt >= lag)
      begin
        fetchDone  <= 1'h1;
        fetchCount <= fetchCount + 16'h1;
        lastAddr   <= fetchAddr;
      end
      else
        waitCnt <= waitCnt + 4'h1;
    end
  end
endmodule : iqr_mem_model

// File: sim/invalidation_queue_registers_tb.sv
/*
  Self-checking bench for the invalidation queue register bank.
  Assumes iqr_regs behind AXI4-Lite and the memory model on the fetch side.
*/
`timescale 1ns/1ps
module invalidation_queue_registers_tb;
  logic        core_clk;
  logic        rst_n;
  logic        qiSupported;
  logic [7:0]  awaddr;
  logic        awvalid;
  logic        awready;
  logic [31:0] wdata;
  logic [3:0]  wstrb;
  logic        wvalid;
  logic        wready;
  logic [1:0]  bresp;
  logic        bvalid;
  logic        bready;
  logic [7:0]  araddr;
  logic        arvalid;
  logic        arready;
  logic [31:0] rdata;
  logic [1:0]  rresp;
  logic        rvalid;
  logic        rready;
  logic        waitDone;
  logic        fetchDone;
  logic        fetchValid;
  logic [63:0] fetchAddr;
  logic        irq;
  logic [3:0]  lag;
  logic [15:0] fetchCount;
  logic [63:0] lastAddr;
  logic [31:0] rd;
  logic [1:0]  rsp;
  logic [7:0]  regList [7];
  int          num_errors;
  int          check_count;

  iqr_regs u_iqr_regs (.core_clk(core_clk), .rst_n(rst_n), .qiSupported(qiSupported),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .waitDone(waitDone), .fetchDone(fetchDone), .fetchValid(fetchValid),
    .fetchAddr(fetchAddr), .irq(irq));

  iqr_mem_model u_iqr_mem_model (.core_clk(core_clk), .rst_n(rst_n), .lag(lag),
    .fetchValid(fetchValid), .fetchAddr(fetchAddr), .fetchDone(fetchDone),
    .fetchCount(fetchCount), .lastAddr(lastAddr));

  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("ERROR %s expected %0h seen %0h", name, exp, seen);
    end
  endtask : check

  task automatic hang;
    num_errors++;
    $display("ERROR timeout on a handshake");
    wrap_up();
  endtask : hang

  // Address and data are offered together and each is dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int   n;
    logic awDone;
    logic wDone;
    n = 0;
    awDone = 1'h0;
    wDone = 1'h0;
    awaddr <= a;
    awvalid <= 1'h1;
    wdata <= d;
    wvalid <= 1'h1;
    bready <= 1'h1;
    while (!(awDone && wDone && bvalid))
    begin
      @(posedge core_clk);
      n++;
      if (n > 100)
        hang();
      if (!awDone && awready)
      begin
        awDone = 1'h1;
        awvalid <= 1'h0;
      end
      if (!wDone && wready)
      begin
        wDone = 1'h1;
        wvalid <= 1'h0;
      end
    end
    r = bresp;
    bready <= 1'h0;
    @(posedge core_clk);
  endtask : wr

  task automatic rdw(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int   n;
    logic arDone;
    n = 0;
    arDone = 1'h0;
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    while (!(arDone && rvalid))
    begin
      @(posedge core_clk);
      n++;
      if (n > 100)
        hang();
      if (!arDone && arready)
      begin
        arDone = 1'h1;
        arvalid <= 1'h0;
      end
    end
    d = rdata;
    r = rresp;
    rready <= 1'h0;
    @(posedge core_clk);
  endtask : rdw

  task automatic wc(input logic [7:0] a, input logic [31:0] d);
    wr(a, d, rsp);
    check($sformatf("bresp %0h", a), rsp, iqr_pkg::RESP_OKAY);
  endtask : wc

  task automatic rc(input logic [7:0] a, input logic [31:0] e);
    rdw(a, rd, rsp);
    check($sformatf("rresp %0h", a), rsp, iqr_pkg::RESP_OKAY);
    check($sformatf("reg %0h", a), rd, e);
  endtask : rc

  task automatic pulse;
    waitDone <= 1'h1;
    @(posedge core_clk);
    waitDone <= 1'h0;
  endtask : pulse

  task automatic wait_fetches(input logic [15:0] want);
    int n;
    n = 0;
    while (fetchCount !== want)
    begin
      @(posedge core_clk);
      n++;
      if (n > 3000)
        hang();
    end
  endtask : wait_fetches

  initial
  begin
    core_clk = 1'h0;
    forever #12.5 core_clk = ~core_clk;
  end

  initial
  begin
    rst_n = 1'h0;
    qiSupported = 1'h1;
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    wstrb = 4'hF;
    {araddr, arvalid, rready, waitDone} = '0;
    lag = 4'h3;
    num_errors = 0;
    check_count = 0;
    regList = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h9C};
    repeat (20) @(posedge core_clk);
    rst_n <= 1'h1;
    repeat (2) @(posedge core_clk);
    foreach (regList[i]) rc(regList[i], 32'h0);
    wc(iqr_pkg::OFF_TAIL_LO, 32'hFFFF_FFFF);
    rc(iqr_pkg::OFF_TAIL_LO, 32'h0007_FFF0);
    wc(iqr_pkg::OFF_TAIL_HI, 32'hFFFF_FFFF);
    rc(iqr_pkg::OFF_TAIL_HI, 32'h0);
    wc(iqr_pkg::OFF_HEAD_LO, 32'hFFFF_FFFF);
    rc(iqr_pkg::OFF_HEAD_LO, 32'h0);
    wc(iqr_pkg::OFF_BASE_LO, 32'hFFFF_FFFF);
    rc(iqr_pkg::OFF_BASE_LO, 32'hFFFF_F007);
    wc(iqr_pkg::OFF_BASE_HI, 32'hFFFF_FFFF);
    rc(iqr_pkg::OFF_BASE_HI, 32'h0000_FFFF);
    wstrb <= 4'h1;
    wc(iqr_pkg::OFF_BASE_HI, 32'h0000_1234);
    wstrb <= 4'hF;
    rc(iqr_pkg::OFF_BASE_HI, 32'h0000_FF34);
    wr(8'h44, 32'h1, rsp);
    check("bresp unmapped", rsp, iqr_pkg::RESP_SLVERR);
    rdw(8'h40, rd, rsp);
    check("rresp unmapped", rsp, iqr_pkg::RESP_SLVERR);
    check("rdata unmapped", rd, 32'h0);
    // Slow memory first, then prompt answers across the wrap of a 256-entry queue
    wc(iqr_pkg::OFF_BASE_HI, 32'h0);
    wc(iqr_pkg::OFF_BASE_LO, 32'h0000_5000);
    wc(iqr_pkg::OFF_TAIL_LO, 32'h30);
    wc(iqr_pkg::OFF_CTRL, 32'h1);
    wait_fetches(16'h3);
    check("last fetch", lastAddr, 64'h5020);
    rc(iqr_pkg::OFF_HEAD_LO, 32'h30);
    check("fetch count", fetchCount, 16'h3);
    lag <= 4'h0;
    wc(iqr_pkg::OFF_TAIL_LO, 32'h10);
    wait_fetches(16'h101);
    check("wrap fetch", lastAddr, 64'h5000);
    rc(iqr_pkg::OFF_HEAD_LO, 32'h10);
    check("wrap count", fetchCount, 16'h101);
    wc(iqr_pkg::OFF_CTRL, 32'h0);
    rc(iqr_pkg::OFF_HEAD_LO, 32'h0);
    wc(iqr_pkg::OFF_IRQ_MASK, 32'h1);
    pulse();
    rc(iqr_pkg::OFF_WAIT_STAT, 32'h1);
    rc(iqr_pkg::OFF_IRQ_STAT, 32'h1);
    check("irq set", irq, 1'h1);
    wc(iqr_pkg::OFF_WAIT_STAT, 32'h0);
    rc(iqr_pkg::OFF_WAIT_STAT, 32'h1);
    wc(iqr_pkg::OFF_IRQ_STAT, 32'h1);
    pulse();
    rc(iqr_pkg::OFF_IRQ_STAT, 32'h0);
    check("irq quiet", irq, 1'h0);
    wc(iqr_pkg::OFF_WAIT_STAT, 32'h1);
    rc(iqr_pkg::OFF_WAIT_STAT, 32'h0);
    pulse();
    rc(iqr_pkg::OFF_IRQ_STAT, 32'h1);
    wc(iqr_pkg::OFF_IRQ_MASK, 32'h0);
    rc(iqr_pkg::OFF_IRQ_MASK, 32'h0);
    check("irq masked", irq, 1'h0);
    qiSupported <= 1'h0;
    wc(iqr_pkg::OFF_TAIL_LO, 32'h40);
    rc(iqr_pkg::OFF_TAIL_LO, 32'h0);
    rc(iqr_pkg::OFF_BASE_LO, 32'h0);
    rc(iqr_pkg::OFF_WAIT_STAT, 32'h0);
    rc(iqr_pkg::OFF_CTRL, 32'h0);
    qiSupported <= 1'h1;
    rc(iqr_pkg::OFF_TAIL_LO, 32'h10);
    wrap_up();
  end
endmodule : invalidation_queue_registers_tb
